/* File: rtl/login_negotiator.sv */
// Login validation and parameter negotiation for one logical unit
// Notes on behaviour
// - Payload sizes travel in 128-byte units, one per direction.
// - Negotiated payload never exceeds two to the twentieth bytes.
// - The unit keeps owner identifier, session owner tag and negotiated limits.
// - Owner identifier goes all ones on reset, release expiry plus 1 s, logout.
// - Same owner with a different session owner tag is rejected.
// - Same owner with different requested parameters is rejected.
// - Service reset only when a new owner is accepted.
// - Accepted login stores the requester identifier and a fresh session tag.
// - Release timeout is the smaller of request and supported maximum.
// - Each direction's payload is the smaller of request and supported size.
// - Inactivity timeout is the smaller of request and supported maximum.
// - A write to the management agent starts a fetch of the request.
// - The speed of that write is kept for the session.
// - Reject when requester already logged in or another node holds the unit.
// - A refusal reports resources unavailable in status.
// - Response carries one extra quadlet with the negotiated minima.
// - Payload fields of that quadlet are in 128-byte units.
// - Every target-to-initiator request uses the negotiated size.
// - No credit within the alive time marks the initiator dead.
// - Alive codes 0..7 map to 100 ms up to 15 s.
// - Resumption codes 0..7 map to 0 s up to 300 s.
// - After implicit logout context is kept for resumption time plus 1 s; resume stops it.
`timescale 1ns/10ps
module login_negotiator
   import login_neg_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        agent_write,
   input  wire logic [1:0]  agent_write_speed,
   output logic             fetch_request,
   input  wire logic        fetch_done,
   input  wire logic [63:0] requester_node_id,
   input  wire logic [31:0] req_session_owner_tag,
   input  wire logic [13:0] req_i2t_units,
   input  wire logic [13:0] req_t2i_units,
   input  wire logic [2:0]  req_alive_code,
   input  wire logic [2:0]  req_resume_code,
   input  wire logic        explicit_logout,
   input  wire logic        implicit_logout,
   input  wire logic        unsol_status_sent,
   input  wire logic        unsol_credit,
   output logic             login_accept,
   output logic             login_reject,
   output logic             status_resources_unavailable,
   output logic             service_reset,
   output logic [31:0]      response_ext_quadlet,
   output logic [15:0]      session_number,
   output logic [63:0]      owner_node_identifier,
   output logic [31:0]      session_owner_tag,
   output logic [1:0]       session_speed,
   output logic [13:0]      t2i_request_units,
   output logic             initiator_dead
);
   import login_neg_pkg::*;

   typedef struct packed {
      state_t      state;
      logic        fetch;
      logic        accept;
      logic        reject;
      logic        svc_reset;
      logic        dead;
      logic [63:0] owner;
      logic [31:0] tag;
      logic [15:0] sess;
      logic [13:0] i2t;
      logic [13:0] t2i;
      logic [2:0]  alive;
      logic [2:0]  resume;
      logic [1:0]  speed;
      logic [1:0]  pend_speed;
      logic [31:0] ext;
      logic [17:0] div;
      logic        alive_run;
      logic [19:0] alive_ms_cnt;
      logic        rel_run;
      logic [20:0] rel_ms_cnt;
      logic [31:0] tag_seed;
   } core_t;

   core_t cur_reg;
   core_t cur_next;
   logic  tick;
   logic  owned;
   logic  same_owner;
   logic  params_match;
   logic  refuse;
   logic [13:0] i2t_min;
   logic [13:0] t2i_min;
   logic [2:0]  alive_min;
   logic [2:0]  resume_min;

   // Negotiated minima and validation terms
   always_comb
   begin
      i2t_min    = (req_i2t_units < SUP_I2T_UNITS) ? req_i2t_units : SUP_I2T_UNITS;
      t2i_min    = (req_t2i_units < SUP_T2I_UNITS) ? req_t2i_units : SUP_T2I_UNITS;
      if (i2t_min > MAX_UNITS) i2t_min = MAX_UNITS;
      if (t2i_min > MAX_UNITS) t2i_min = MAX_UNITS;
      resume_min = (req_resume_code < SUP_RESUME_CODE) ? req_resume_code : SUP_RESUME_CODE;
      alive_min  = (req_alive_code < SUP_ALIVE_CODE) ? req_alive_code : SUP_ALIVE_CODE;
      owned        = (cur_reg.owner != OWNER_NONE);
      same_owner   = owned && (cur_reg.owner == requester_node_id);
      params_match = (i2t_min == cur_reg.i2t) && (t2i_min == cur_reg.t2i)
                     && (alive_min == cur_reg.alive) && (resume_min == cur_reg.resume);
      // A live session blocks all; a released owner may resume with tag and limits
      refuse = (owned && !cur_reg.rel_run)
               || (same_owner && req_session_owner_tag != cur_reg.tag)
               || (same_owner && !params_match)
               || (owned && !same_owner);
      tick = (cur_reg.div == TICK_LAST);
   end

   // Next-state logic
   always_comb
   begin
      cur_next        = cur_reg;
      cur_next.fetch  = 1'b0;
      cur_next.accept = 1'b0;
      cur_next.reject = 1'b0;
      cur_next.svc_reset = 1'b0;
      cur_next.div    = tick ? 18'h00000 : cur_reg.div + 18'h00001;
      cur_next.tag_seed = cur_reg.tag_seed + 32'h00000001;
      case (cur_reg.state)
         ST_IDLE:
         begin
            if (agent_write)
            begin
               cur_next.fetch = 1'b1;
               cur_next.pend_speed = agent_write_speed;
               cur_next.state = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            if (fetch_done) cur_next.state = ST_CHECK;
         end
         ST_CHECK:
         begin
            if (refuse)
               cur_next.reject = 1'b1;
            else
            begin
               cur_next.accept    = 1'b1;
               cur_next.svc_reset = !same_owner;
               cur_next.speed     = cur_reg.pend_speed;
               cur_next.owner     = requester_node_id;
               cur_next.tag       = (cur_reg.tag_seed == 32'h00000000) ? 32'h00000001 : cur_reg.tag_seed;
               cur_next.sess      = cur_reg.sess + 16'h0001;
               cur_next.i2t       = i2t_min;
               cur_next.t2i       = t2i_min;
               cur_next.alive     = alive_min;
               cur_next.resume    = resume_min;
               cur_next.rel_run   = 1'b0;
               cur_next.rel_ms_cnt = 21'h000000;
               cur_next.dead      = 1'b0;
               // Extended quadlet: i2t, alive, t2i, resume
               cur_next.ext = {i2t_min[12:0], alive_min, t2i_min[12:0], resume_min};
            end
            cur_next.state = ST_DONE;
         end
         ST_DONE:  cur_next.state = ST_IDLE;
         default:  cur_next.state = ST_IDLE;
      endcase
      // Transport alive watchdog
      if (unsol_status_sent)
      begin
         cur_next.alive_run    = 1'b1;
         cur_next.alive_ms_cnt = 20'h00000;
      end
      else if (unsol_credit)
         cur_next.alive_run = 1'b0;
      else if (cur_reg.alive_run && tick)
      begin
         if (cur_reg.alive_ms_cnt + 20'h00001 >= alive_ms(cur_reg.alive))
         begin
            cur_next.alive_run = 1'b0;
            cur_next.dead      = 1'b1;
            cur_next.owner     = OWNER_NONE;
         end
         else
            cur_next.alive_ms_cnt = cur_reg.alive_ms_cnt + 20'h00001;
      end
      // Release watchdog after implicit logout
      if (implicit_logout && owned)
      begin
         cur_next.rel_run    = 1'b1;
         cur_next.rel_ms_cnt = 21'h000000;
      end
      else if (cur_reg.rel_run && tick)
      begin
         if (cur_reg.rel_ms_cnt + 21'h000001 >= {1'b0, resume_ms(cur_reg.resume)} + 21'(GRACE_MS))
         begin
            cur_next.rel_run = 1'b0;
            cur_next.owner   = OWNER_NONE;
         end
         else
            cur_next.rel_ms_cnt = cur_reg.rel_ms_cnt + 21'h000001;
      end
      if (explicit_logout)
      begin
         cur_next.owner   = OWNER_NONE;
         cur_next.rel_run = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cur_reg        <= '0;
         cur_reg.state  <= ST_IDLE;
         cur_reg.owner  <= OWNER_NONE;
         cur_reg.speed  <= SPD_S100;
         cur_reg.pend_speed <= SPD_S100;
      end
      else
         cur_reg <= cur_next;
   end

   // Outputs straight from the state register
   assign fetch_request                = cur_reg.fetch;
   assign login_accept                 = cur_reg.accept;
   assign login_reject                 = cur_reg.reject;
   assign status_resources_unavailable = cur_reg.reject;
   assign service_reset                = cur_reg.svc_reset;
   assign response_ext_quadlet         = cur_reg.ext;
   assign session_number               = cur_reg.sess;
   assign owner_node_identifier        = cur_reg.owner;
   assign session_owner_tag            = cur_reg.tag;
   assign session_speed                = cur_reg.speed;
   assign t2i_request_units            = cur_reg.t2i;
   assign initiator_dead               = cur_reg.dead;

   // Login handshake: fetch follows the agent write, its speed serves the session
   a_fetch_follows_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_IDLE && agent_write |=> fetch_request) else $error("no fetch after write");
   a_speed_kept: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_IDLE && agent_write |=> cur_reg.pend_speed == $past(agent_write_speed))
      else $error("speed");
   a_speed_on_accept: assert property (@(posedge clk_sys) disable iff (sys_rst)
      login_accept |-> session_speed == cur_reg.pend_speed) else $error("session speed not from write");
   a_speed_held_reject: assert property (@(posedge clk_sys) disable iff (sys_rst)
      login_reject |-> $stable(session_speed)) else $error("refused login changed speed");

   // Refusal of live, foreign or mismatched logins
   a_reject_live_owner: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && owned && !cur_reg.rel_run |=> login_reject) else $error("live session taken");
   a_reject_other_owner: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && owned && !same_owner |=> login_reject) else $error("foreign login accepted");
   a_reject_tag_mismatch: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && same_owner && req_session_owner_tag != cur_reg.tag |=> login_reject)
      else $error("tag mismatch accepted");
   a_reject_param_mismatch: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && same_owner && !params_match |=> login_reject) else $error("params accepted");
   a_reject_reports_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
      login_reject |-> status_resources_unavailable) else $error("refusal without status");

   // Accepted login: owner, tag, service reset and negotiated limits
   a_reset_new_owner: assert property (@(posedge clk_sys) disable iff (sys_rst)
      login_accept |-> service_reset == ($past(cur_reg.owner) != owner_node_identifier))
      else $error("svc reset");
   a_accept_stores_owner: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && !refuse && !explicit_logout && !tick
      |=> owner_node_identifier == $past(requester_node_id)) else $error("owner not stored");
   a_accept_fresh_tag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      login_accept |-> session_owner_tag != $past(session_owner_tag) && session_owner_tag != 32'h00000000)
      else $error("tag not fresh");
   a_accept_min_t2i: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && !refuse |=> t2i_request_units <= SUP_T2I_UNITS
      && t2i_request_units <= $past(req_t2i_units)
      && (t2i_request_units == SUP_T2I_UNITS || t2i_request_units == $past(req_t2i_units))) else $error("t2i size");
   a_accept_min_alive: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && !refuse |=> cur_reg.alive <= $past(req_alive_code)
      && (cur_reg.alive == SUP_ALIVE_CODE || cur_reg.alive == $past(req_alive_code))) else $error("alive code");
   a_accept_min_resume: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && !refuse |=> cur_reg.resume <= $past(req_resume_code)
      && (cur_reg.resume == SUP_RESUME_CODE || cur_reg.resume == $past(req_resume_code))) else $error("resume code");
   a_resume_stops_timer: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cur_reg.state == ST_CHECK && !refuse && !implicit_logout |=> !cur_reg.rel_run) else $error("timer kept");

   // Extended response quadlet
   a_ext_t2i_field: assert property (@(posedge clk_sys) disable iff (sys_rst)
      login_accept |-> response_ext_quadlet[15:3] == t2i_request_units[12:0]) else $error("ext field");
   a_ext_code_fields: assert property (@(posedge clk_sys) disable iff (sys_rst)
      login_accept |-> response_ext_quadlet[18:16] == cur_reg.alive && response_ext_quadlet[2:0] == cur_reg.resume)
      else $error("ext codes");

   // Limits and release of the owner
   a_payload_bounded: assert property (@(posedge clk_sys) disable iff (sys_rst)
      t2i_request_units <= MAX_UNITS && cur_reg.i2t <= MAX_UNITS) else $error("payload too big");
   a_logout_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
      explicit_logout |=> owner_node_identifier == OWNER_NONE) else $error("owner kept after logout");
   a_dead_clears_owner: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(initiator_dead) |-> owner_node_identifier == OWNER_NONE) else $error("owner kept when dead");

   // Main scenarios
   c_accept: cover property (@(posedge clk_sys) login_accept);
   c_reject: cover property (@(posedge clk_sys) login_reject);
   c_dead: cover property (@(posedge clk_sys) initiator_dead);
   c_resume: cover property (@(posedge clk_sys) login_accept && !service_reset);
   c_new_owner: cover property (@(posedge clk_sys) login_accept && service_reset);
endmodule // login_negotiator

/* File: rtl/login_neg_pkg.sv */
// Constants for the login access-control negotiator
package login_neg_pkg;
   localparam int          CLK_HZ          = 200000000;
   localparam int          TICK_HZ         = 1000;
   localparam int          TICK_DIV        = CLK_HZ / TICK_HZ;
   localparam logic [17:0] TICK_LAST       = 18'(TICK_DIV - 1);
   localparam logic [63:0] OWNER_NONE      = 64'hFFFFFFFFFFFFFFFF;
   localparam int          UNIT_BYTES      = 128;
   localparam int          MAX_BYTES       = 1048576;
   localparam logic [13:0] MAX_UNITS       = 14'(MAX_BYTES / UNIT_BYTES);
   localparam logic [2:0]  SUP_ALIVE_CODE  = 3'h7;
   localparam logic [2:0]  SUP_RESUME_CODE = 3'h7;
   localparam logic [13:0] SUP_I2T_UNITS   = 14'h2000;
   localparam logic [13:0] SUP_T2I_UNITS   = 14'h2000;
   localparam logic [1:0]  SPD_S100        = 2'h0;
   localparam logic [15:0] GRACE_MS        = 16'h03E8;
   typedef logic [19:0] ms_t;
   // Transport alive code to milliseconds
   function automatic ms_t alive_ms(input logic [2:0] c);
      case (c)
         3'h0: alive_ms = 20'h00064;
         3'h1: alive_ms = 20'h000C8;
         3'h2: alive_ms = 20'h001F4;
         3'h3: alive_ms = 20'h003E8;
         3'h4: alive_ms = 20'h00BB8;
         3'h5: alive_ms = 20'h01388;
         3'h6: alive_ms = 20'h02710;
         default: alive_ms = 20'h03A98;
      endcase
   endfunction
   // Resumption code to milliseconds
   function automatic ms_t resume_ms(input logic [2:0] c);
      case (c)
         3'h0: resume_ms = 20'h00000;
         3'h1: resume_ms = 20'h01388;
         3'h2: resume_ms = 20'h02710;
         3'h3: resume_ms = 20'h03A98;
         3'h4: resume_ms = 20'h07530;
         3'h5: resume_ms = 20'h0EA60;
         3'h6: resume_ms = 20'h1D4C0;
         default: resume_ms = 20'h493E0;
      endcase
   endfunction
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_CHECK, ST_DONE} state_t;
endpackage

/* File: tb/initiator_model.sv */
// Remote initiator model that performs the login handshake
`timescale 1ns/10ps
module initiator_model (
   input  wire logic        clk_sys,
   input  wire logic        fetch_request,
   input  wire logic        login_accept,
   input  wire logic        login_reject,
   input  wire logic        status_resources_unavailable,
   input  wire logic        service_reset,
   output logic             agent_write,
   output logic [1:0]       agent_write_speed,
   output logic             fetch_done,
   output logic [63:0]      requester_node_id,
   output logic [31:0]      req_session_owner_tag,
   output logic [13:0]      req_i2t_units,
   output logic [13:0]      req_t2i_units,
   output logic [2:0]       req_alive_code,
   output logic [2:0]       req_resume_code
);
   int n;
   // Quiet bus until the first login
   initial
   begin
      agent_write = 1'b0;
      fetch_done = 1'b0;
      agent_write_speed = 2'h3;
      {requester_node_id, req_session_owner_tag, req_i2t_units, req_t2i_units, req_alive_code, req_resume_code} = '0;
   end
   // Management write, request hand-over, then collect the verdict pulses
   task automatic login(input logic [63:0] nid, input logic [31:0] tag, input logic [13:0] i2t, t2i,
                        input logic [2:0] al, rs, input logic [1:0] spd, input int lag,
                        output logic [3:0] seen, output bit hung);
      seen = 4'h0;
      @(negedge clk_sys);
      agent_write = 1'b1;
      agent_write_speed = spd;
      @(negedge clk_sys);
      agent_write = 1'b0;
      agent_write_speed = ~spd;
      for (n = 0; n < 8 && fetch_request !== 1'b1; n++) @(negedge clk_sys);
      hung = (n == 8);
      repeat (lag) @(negedge clk_sys);
      // Sizes are already in 128-byte units; tag is zero for new access
      {requester_node_id, req_session_owner_tag, req_i2t_units, req_t2i_units, req_alive_code, req_resume_code} =
         {nid, tag, i2t, t2i, al, rs};
      fetch_done = 1'b1;
      @(negedge clk_sys);
      fetch_done = 1'b0;
      for (n = 0; n < 8 && seen === 4'h0; n++)
      begin
         @(negedge clk_sys);
         seen = {login_accept, login_reject, status_resources_unavailable, service_reset};
      end
      hung = hung || (seen === 4'h0);
      // Request no longer held: show inverted values so stale data cannot pass
      {requester_node_id, req_session_owner_tag, req_i2t_units, req_t2i_units, req_alive_code, req_resume_code} =
         ~{nid, tag, i2t, t2i, al, rs};
   endtask
endmodule // initiator_model

/* File: tb/login_negotiator_test.sv */
// Self-checking bench for the login negotiator
`timescale 1ns/10ps
module login_negotiator_test;
   import login_neg_pkg::*;
   logic        clk_sys, sys_rst, agent_write, fetch_request, fetch_done, explicit_logout, implicit_logout;
   logic        unsol_status_sent, unsol_credit, login_accept, login_reject, status_resources_unavailable;
   logic        service_reset, initiator_dead, m_win, hung;
   logic [1:0]  agent_write_speed, session_speed, m_spd, spd;
   logic [2:0]  req_alive_code, req_resume_code, m_al, m_rs;
   logic [3:0]  seen;
   logic [13:0] req_i2t_units, req_t2i_units, t2i_request_units, m_i2t, m_t2i;
   logic [15:0] session_number, m_sess;
   logic [31:0] req_session_owner_tag, session_owner_tag, response_ext_quadlet, m_tag;
   logic [63:0] requester_node_id, owner_node_identifier, m_owner, id;
   int          n_fail, checks_done, seed;
   login_negotiator u_login_negotiator (.clk_sys(clk_sys), .sys_rst(sys_rst), .agent_write(agent_write),
      .agent_write_speed(agent_write_speed), .fetch_request(fetch_request), .fetch_done(fetch_done),
      .requester_node_id(requester_node_id), .req_session_owner_tag(req_session_owner_tag),
      .req_i2t_units(req_i2t_units), .req_t2i_units(req_t2i_units), .req_alive_code(req_alive_code),
      .req_resume_code(req_resume_code), .explicit_logout(explicit_logout), .implicit_logout(implicit_logout),
      .unsol_status_sent(unsol_status_sent), .unsol_credit(unsol_credit), .login_accept(login_accept),
      .login_reject(login_reject), .status_resources_unavailable(status_resources_unavailable),
      .service_reset(service_reset), .response_ext_quadlet(response_ext_quadlet), .session_number(session_number),
      .owner_node_identifier(owner_node_identifier), .session_owner_tag(session_owner_tag),
      .session_speed(session_speed), .t2i_request_units(t2i_request_units), .initiator_dead(initiator_dead));
   initiator_model u_initiator_model (.clk_sys(clk_sys), .fetch_request(fetch_request), .login_accept(login_accept),
      .login_reject(login_reject), .status_resources_unavailable(status_resources_unavailable),
      .service_reset(service_reset), .agent_write(agent_write), .agent_write_speed(agent_write_speed),
      .fetch_done(fetch_done), .requester_node_id(requester_node_id), .req_session_owner_tag(req_session_owner_tag),
      .req_i2t_units(req_i2t_units), .req_t2i_units(req_t2i_units), .req_alive_code(req_alive_code),
      .req_resume_code(req_resume_code));
   // 200 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [13:0] mn(input logic [13:0] a, b);
      return (a < b) ? a : b;
   endfunction
   // Verdict and end of run
   task automatic end_sim();
      if (n_fail == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] got, exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle pulse on {explicit, implicit, status sent, credit}
   task automatic pulse(input logic [3:0] sel);
      @(negedge clk_sys);
      {explicit_logout, implicit_logout, unsol_status_sent, unsol_credit} = sel;
      @(negedge clk_sys);
      {explicit_logout, implicit_logout, unsol_status_sent, unsol_credit} = 4'h0;
      @(negedge clk_sys);
   endtask
   // One login predicted by the access-control model and compared
   task automatic try(input logic [63:0] nid, input logic [31:0] tag, input logic [13:0] i2t, t2i,
                      input logic [2:0] al, rs);
      logic ok;
      ok = (m_owner === OWNER_NONE) || (m_owner === nid && m_win && tag === m_tag
           && mn(i2t, SUP_I2T_UNITS) === m_i2t && mn(t2i, SUP_T2I_UNITS) === m_t2i && al === m_al && rs === m_rs);
      u_initiator_model.login(nid, tag, i2t, t2i, al, rs, spd, $unsigned($random(seed)) % 4, seen, hung);
      if (hung)
      begin
         n_fail++;
         end_sim();
      end
      chk("accept", seen[3], ok);
      chk("reject", seen[2:1], {2{!ok}});
      chk("service reset", seen[0], ok && m_owner !== nid);
      if (ok)
      begin
         chk("fresh tag", session_owner_tag !== m_tag && session_owner_tag !== 32'h0, 1'b1);
         m_i2t = mn(i2t, SUP_I2T_UNITS);
         m_t2i = mn(t2i, SUP_T2I_UNITS);
         m_al = (al < SUP_ALIVE_CODE) ? al : SUP_ALIVE_CODE;
         m_rs = (rs < SUP_RESUME_CODE) ? rs : SUP_RESUME_CODE;
         m_owner = nid;
         m_tag = session_owner_tag;
         m_win = 1'b0;
         m_spd = spd;
         m_sess = m_sess + 16'h0001;
      end
      chk("owner", owner_node_identifier, m_owner);
      chk("quadlet", response_ext_quadlet, {m_i2t[12:0], m_al, m_t2i[12:0], m_rs});
      chk("speed", session_speed, m_spd);
      chk("session", session_number, m_sess);
      chk("t2i size", t2i_request_units, m_t2i);
      chk("size limit", t2i_request_units <= MAX_UNITS, 1'b1);
   endtask
   // Reset, then login, refusals, resumption and logout for every code
   initial
   begin
      seed = 32'hF3D14E18;
      n_fail = 0;
      checks_done = 0;
      {explicit_logout, implicit_logout, unsol_status_sent, unsol_credit} = 4'h0;
      {m_owner, m_tag, m_win, m_i2t, m_t2i, m_al, m_rs, m_spd, spd} = {OWNER_NONE, 32'h0, 39'h0};
      m_sess = 16'h0000;
      sys_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      chk("reset owner", owner_node_identifier, OWNER_NONE);
      chk("reset quadlet", response_ext_quadlet, 32'h0);
      for (int k = 0; k < 8; k++)
      begin
         id = {$random(seed), $random(seed)} & ~64'h1;
         spd = 2'(k % 3);
         try(id, 32'h0, 14'($random(seed)), 14'($random(seed)), 3'(k), 3'(7 - k));
         try(id, m_tag, m_i2t, m_t2i, m_al, m_rs);
         spd = 2'(k % 3 + 1); // A refused write at another speed leaves the session speed alone
         try(~id, 32'h0, m_i2t, m_t2i, m_al, m_rs);
         pulse(4'h2);
         pulse(4'h1);
         chk("alive", initiator_dead, 1'b0);
         pulse(4'h4);
         m_win = 1'b1;
         chk("kept owner", owner_node_identifier, id);
         try(id, m_tag ^ 32'h1, m_i2t, m_t2i, m_al, m_rs);
         try(id, m_tag, m_i2t - 14'h1, m_t2i, m_al, m_rs);
         try(id, m_tag, m_i2t, m_t2i, m_al, m_rs);
         pulse(4'h8);
         m_owner = OWNER_NONE;
         m_win = 1'b0;
         chk("logout owner", owner_node_identifier, OWNER_NONE);
      end
      end_sim();
   end
endmodule // login_negotiator_test
